// *** ecch_pkg.sv ***
package ecch_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int BYTE_W = 8;
   localparam logic [2:0] LAST_BIT = 3'h7;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_ERR_STAT = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_LAST_CMD = 8'h10;
   localparam int CTRL_TWO_TIME = 0;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [7:0] CMD_ERROR_CLEAR = 8'hFF;
   // Opcode heads of the eight two-byte commands
   localparam logic [3:0] HEAD_PLAY           = 4'h4;
   localparam logic [3:0] HEAD_ANALOG_SETUP   = 4'h7;
   localparam logic [3:0] HEAD_ANALOG_VOLUME  = 4'h8;
   localparam logic [3:0] HEAD_RAMP_LEVEL     = 4'h9;
   localparam logic [3:0] HEAD_RAMP_RATE      = 4'hA;
   localparam logic [3:0] HEAD_SILENCE_INSERT = 4'hB;
   localparam logic [3:0] HEAD_PROTECT_SETUP  = 4'hD;
   localparam logic [3:0] HEAD_CHANNEL_VOLUME = 4'hE;
   localparam int IRQ_W = 3;
   localparam int IRQ_ERR_RISE = 0;
   localparam int IRQ_XFER     = 1;
   localparam int IRQ_CMD_DONE = 2;
   localparam logic [IRQ_W-1:0] IRQ_NONE = 3'h0;

   typedef struct packed {
      logic spkShort;
      logic romFault;
      logic underVolt;
      logic overTemp;
   } ecch_cond_t;

   typedef struct packed {
      logic spkShort;
      logic romFault;
      logic xferFault;
      logic underVolt;
      logic overTemp;
   } ecch_flags_t;

   localparam ecch_flags_t FLAGS_NONE = 5'h00;

   typedef struct packed {
      logic             twoByte;
      logic [BYTE_W-1:0] arg;
      logic [BYTE_W-1:0] op;
   } ecch_cmd_t;

   typedef enum logic [1:0] {
      ST_OPCODE  = 2'b00,
      ST_ARG     = 2'b01,
      ST_REP_OP  = 2'b10,
      ST_REP_ARG = 2'b11
   } ecch_state_t;

   function automatic logic isTwoByte(input logic [BYTE_W-1:0] op);
      case (op[7:4])
         HEAD_PLAY, HEAD_ANALOG_SETUP, HEAD_ANALOG_VOLUME, HEAD_RAMP_LEVEL,
         HEAD_RAMP_RATE, HEAD_SILENCE_INSERT, HEAD_PROTECT_SETUP,
         HEAD_CHANNEL_VOLUME: isTwoByte = 1'b1;
         default: isTwoByte = 1'b0;
      endcase
   endfunction
endpackage

// *** ecch_top.sv ***
// Behaviour
// R1: An all-ones single command byte is the error-clear command.
// R2: Any monitored error drives the error pin high until cleared.
// R3: The error-clear command returns the error pin low.
// R4: Persisting over-temperature or undervoltage keeps flags and pin high despite clear.
// R5: Power, start/stop, loop, status-pin and error-clear commands are one byte.
// R6: Analog, volume, ramp, play, silence, channel-volume, protection commands are two bytes.
// R7: Two-time mode repeats each two-byte command; device checks the repeat first.
// R8: Host recovers speaker short by status read, amplifier power-down, then clear.
// R9: A failed two-time transfer sets the transfer-fault flag.
// R10: Error-clear also drops latched flags whose cause has ended.
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
module ecch_top
   import ecch_pkg::*;
(
   input  wire logic              clock,         // 100 MHz clock
   input  wire logic              rst_n,         // Async reset
   input  wire logic              ce,            // Clock enable
   input  wire logic              csbN,          // Serial chip select pin
   input  wire logic              sck,           // Serial clock pin
   input  wire logic              si,            // Serial data pin
   input  wire ecch_cond_t        errCond,       // Monitor levels, same clock
   output logic                   errPin,        // Error output pin
   output logic                   cmdValid,      // Command accepted pulse
   output ecch_cmd_t              cmdOut,        // Accepted command
   output logic                   irq,           // Interrupt level
   input  wire logic              awvalid,       // AXI write address valid
   output logic                   awready,       // AXI write address ready
   input  wire logic [ADDR_W-1:0] awaddr,        // AXI write address
   input  wire logic              wvalid,        // AXI write data valid
   output logic                   wready,        // AXI write data ready
   input  wire logic [DATA_W-1:0] wdata,         // AXI write data
   input  wire logic [3:0]        wstrb,         // AXI write strobes
   output logic                   bvalid,        // AXI write response valid
   input  wire logic              bready,        // AXI write response ready
   output logic [1:0]             bresp,         // AXI write response
   input  wire logic              arvalid,       // AXI read address valid
   output logic                   arready,       // AXI read address ready
   input  wire logic [ADDR_W-1:0] araddr,        // AXI read address
   output logic                   rvalid,        // AXI read data valid
   input  wire logic              rready,        // AXI read data ready
   output logic [DATA_W-1:0]      rdata,         // AXI read data
   output logic [1:0]             rresp          // AXI read response
);
   logic              rstMeta_ff;
   logic              rstSyncN_ff;
   logic [2:0]        pinMeta_ff;
   logic [2:0]        pinSync_ff;
   logic              sckPrev_ff;
   logic [2:0]        bitCnt_ff;
   logic [BYTE_W-1:0] shift_ff;
   logic              byteStb_ff;
   logic [BYTE_W-1:0] byte_ff;
   ecch_state_t       state_ff;
   logic [BYTE_W-1:0] opHold_ff;
   logic [BYTE_W-1:0] argHold_ff;
   logic [BYTE_W-1:0] opRep_ff;
   ecch_flags_t       flags_ff;
   ecch_flags_t       nxt_flags;
   logic              errPin_ff;
   logic              cmdValid_ff;
   ecch_cmd_t         cmd_ff;
   logic              twoTime_ff;
   logic [IRQ_W-1:0]  irqStat_ff;
   logic [IRQ_W-1:0]  irqMask_ff;
   logic              awHeld_ff;
   logic [ADDR_W-1:0] awAddr_ff;
   logic              wHeld_ff;
   logic [DATA_W-1:0] wData_ff;
   logic              wLane0_ff;
   logic              bvalid_ff;
   logic [1:0]        bresp_ff;
   logic              rvalid_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic [1:0]        rresp_ff;
   logic              sckRise;
   logic              errClr;
   logic              xferSet;
   logic              accept;
   logic              doWrite;
   logic              wrOk;

   // Reset released through two flops
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_ff  <= 1'b0;
         rstSyncN_ff <= 1'b0;
      end else begin
         rstMeta_ff  <= 1'b1;
         rstSyncN_ff <= rstMeta_ff;
      end
   end

   // Host pins cross in through two flops; reset to idle levels so no false edge
   always_ff @(posedge clock or negedge rstSyncN_ff) begin
      if (!rstSyncN_ff) begin
         pinMeta_ff <= 3'h6;
         pinSync_ff <= 3'h6;
         sckPrev_ff <= 1'b1;
      end else if (ce) begin
         pinMeta_ff <= {csbN, sck, si};
         pinSync_ff <= pinMeta_ff;
         sckPrev_ff <= pinSync_ff[1];
      end
   end

   assign sckRise = pinSync_ff[1] && !sckPrev_ff && !pinSync_ff[2];

   // Deselect drops a partial byte
   always_ff @(posedge clock or negedge rstSyncN_ff) begin
      if (!rstSyncN_ff) begin
         bitCnt_ff  <= 3'h0;
         shift_ff   <= 8'h00;
         byteStb_ff <= 1'b0;
         byte_ff    <= 8'h00;
      end else if (ce) begin
         byteStb_ff <= 1'b0;
         if (pinSync_ff[2]) begin
            bitCnt_ff <= 3'h0;
         end else if (sckRise) begin
            shift_ff  <= {shift_ff[6:0], pinSync_ff[0]};
            bitCnt_ff <= bitCnt_ff + 3'h1;
            if (bitCnt_ff == LAST_BIT) begin
               byteStb_ff <= 1'b1;
               byte_ff    <= {shift_ff[6:0], pinSync_ff[0]};
            end
         end
      end
   end

   assign errClr = byteStb_ff && state_ff == ST_OPCODE
                   && byte_ff == CMD_ERROR_CLEAR; // R1
   assign xferSet = byteStb_ff && state_ff == ST_REP_ARG
                    && (byte_ff != argHold_ff || opRep_ff != opHold_ff); // R7
   assign accept = byteStb_ff && ((state_ff == ST_OPCODE && !isTwoByte(byte_ff))
                   || (state_ff == ST_ARG && !twoTime_ff)
                   || (state_ff == ST_REP_ARG && !xferSet));

   // Mode is sampled per byte; change it only between commands
   always_ff @(posedge clock or negedge rstSyncN_ff) begin
      if (!rstSyncN_ff) begin
         state_ff   <= ST_OPCODE;
         opHold_ff  <= 8'h00;
         argHold_ff <= 8'h00;
         opRep_ff   <= 8'h00;
      end else if (ce && byteStb_ff) begin
         case (state_ff)
            ST_OPCODE: begin
               opHold_ff <= byte_ff;
               if (isTwoByte(byte_ff))
                  state_ff <= ST_ARG; // R6
               else
                  state_ff <= ST_OPCODE; // R5
            end
            ST_ARG: begin
               argHold_ff <= byte_ff;
               state_ff   <= twoTime_ff ? ST_REP_OP : ST_OPCODE; // R6 R7
            end
            ST_REP_OP: begin
               opRep_ff <= byte_ff;
               state_ff <= ST_REP_ARG; // R7
            end
            ST_REP_ARG: state_ff <= ST_OPCODE;
            default: state_ff <= ST_OPCODE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstSyncN_ff) begin
      if (!rstSyncN_ff) begin
         cmdValid_ff <= 1'b0;
         cmd_ff      <= '0;
      end else if (ce) begin
         cmdValid_ff <= accept;
         if (accept) begin
            cmd_ff.twoByte <= state_ff != ST_OPCODE;
            cmd_ff.op      <= (state_ff == ST_OPCODE) ? byte_ff : opHold_ff;
            cmd_ff.arg     <= (state_ff == ST_OPCODE) ? 8'h00
                              : (state_ff == ST_ARG) ? byte_ff : argHold_ff;
         end
      end
   end

   // Live condition always wins, so a persisting fault survives a clear
   always_comb begin
      nxt_flags.overTemp  = errCond.overTemp || (flags_ff.overTemp && !errClr); // R4 R10
      nxt_flags.underVolt = errCond.underVolt || (flags_ff.underVolt && !errClr); // R4 R10
      nxt_flags.spkShort  = errCond.spkShort || (flags_ff.spkShort && !errClr); // R10
      nxt_flags.romFault  = errCond.romFault || (flags_ff.romFault && !errClr); // R10
      nxt_flags.xferFault = xferSet || (flags_ff.xferFault && !errClr); // R9
   end

   always_ff @(posedge clock or negedge rstSyncN_ff) begin
      if (!rstSyncN_ff) begin
         flags_ff  <= FLAGS_NONE;
         errPin_ff <= 1'b0;
      end else if (ce) begin
         flags_ff  <= nxt_flags;
         errPin_ff <= |nxt_flags; // R2 R3 R4
      end
   end

   // AXI4-Lite write path
   assign awready = !awHeld_ff;
   assign wready  = !wHeld_ff;
   assign doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;
   assign wrOk    = doWrite && wLane0_ff;

   always_ff @(posedge clock or negedge rstSyncN_ff) begin
      if (!rstSyncN_ff) begin
         awHeld_ff <= 1'b0;
         awAddr_ff <= 8'h00;
         wHeld_ff  <= 1'b0;
         wData_ff  <= '0;
         wLane0_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end else if (ce) begin
         if (awvalid && awready) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= awaddr;
         end else if (doWrite) begin
            awHeld_ff <= 1'b0;
         end
         if (wvalid && wready) begin
            wHeld_ff  <= 1'b1;
            wData_ff  <= wdata;
            wLane0_ff <= wstrb[0];
         end else if (doWrite) begin
            wHeld_ff <= 1'b0;
         end
         if (doWrite) begin
            bvalid_ff <= 1'b1;
            case (awAddr_ff)
               ADDR_CTRL, ADDR_ERR_STAT, ADDR_IRQ_STAT, ADDR_IRQ_MASK,
               ADDR_LAST_CMD: bresp_ff <= RESP_OKAY;
               default: bresp_ff <= RESP_SLVERR;
            endcase
         end else if (bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rstSyncN_ff) begin
      if (!rstSyncN_ff) begin
         twoTime_ff <= 1'b0;
         irqMask_ff <= IRQ_NONE;
      end else if (ce && wrOk) begin
         if (awAddr_ff == ADDR_CTRL)
            twoTime_ff <= wData_ff[CTRL_TWO_TIME];
         if (awAddr_ff == ADDR_IRQ_MASK)
            irqMask_ff <= wData_ff[IRQ_W-1:0];
      end
   end

   // Sticky events; a new event beats a same-cycle clear
   always_ff @(posedge clock or negedge rstSyncN_ff) begin
      if (!rstSyncN_ff) begin
         irqStat_ff <= IRQ_NONE;
      end else if (ce) begin
         irqStat_ff <= (irqStat_ff & ~((wrOk && awAddr_ff == ADDR_IRQ_STAT)
                        ? wData_ff[IRQ_W-1:0] : IRQ_NONE))
                       | {accept, xferSet, (|nxt_flags) && !errPin_ff};
      end
   end

   // AXI4-Lite read path, answer one cycle after the address
   assign arready = !rvalid_ff;

   always_ff @(posedge clock or negedge rstSyncN_ff) begin
      if (!rstSyncN_ff) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= '0;
         rresp_ff  <= RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= RESP_OKAY;
            rdata_ff  <= '0;
            case (araddr)
               ADDR_CTRL:     rdata_ff[CTRL_TWO_TIME] <= twoTime_ff;
               ADDR_ERR_STAT: rdata_ff[4:0] <= flags_ff;
               ADDR_IRQ_STAT: rdata_ff[IRQ_W-1:0] <= irqStat_ff;
               ADDR_IRQ_MASK: rdata_ff[IRQ_W-1:0] <= irqMask_ff;
               ADDR_LAST_CMD: rdata_ff[16:0] <= cmd_ff;
               default:       rresp_ff <= RESP_SLVERR;
            endcase
         end else if (rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   assign errPin   = errPin_ff;
   assign cmdValid = cmdValid_ff;
   assign cmdOut   = cmd_ff;
   assign irq      = |(irqStat_ff & irqMask_ff);
   assign bvalid   = bvalid_ff;
   assign bresp    = bresp_ff;
   assign rvalid   = rvalid_ff;
   assign rdata    = rdata_ff;
   assign rresp    = rresp_ff;

   chk_clear_opcode: assert property (@(posedge clock) disable iff (!rstSyncN_ff) // R1
      ce && byteStb_ff && state_ff == ST_OPCODE && byte_ff == CMD_ERROR_CLEAR
      |=> !flags_ff.xferFault && cmdValid_ff && !cmd_ff.twoByte)
      else $error("error clear not recognised");

   chk_err_pin_set: assert property (@(posedge clock) disable iff (!rstSyncN_ff) // R2
      ce && (|errCond) |=> errPin_ff && (|flags_ff))
      else $error("error pin not raised");

   chk_err_pin_low: assert property (@(posedge clock) disable iff (!rstSyncN_ff) // R3
      ce && errClr && !(|errCond) |=> !errPin_ff)
      else $error("error pin not lowered by clear");

   chk_persist_hold: assert property (@(posedge clock) disable iff (!rstSyncN_ff) // R4
      ce && errClr && (errCond.overTemp || errCond.underVolt)
      |=> errPin_ff && (flags_ff.overTemp || flags_ff.underVolt))
      else $error("persisting fault cleared");

   chk_one_byte: assert property (@(posedge clock) disable iff (!rstSyncN_ff) // R5
      ce && byteStb_ff && state_ff == ST_OPCODE && !isTwoByte(byte_ff)
      |=> cmdValid_ff && state_ff == ST_OPCODE && cmd_ff.op == $past(byte_ff))
      else $error("one-byte command not taken");

   chk_two_byte: assert property (@(posedge clock) disable iff (!rstSyncN_ff) // R6
      ce && byteStb_ff && state_ff == ST_OPCODE && isTwoByte(byte_ff)
      |=> !cmdValid_ff && state_ff == ST_ARG)
      else $error("two-byte command taken early");

   chk_repeat_check: assert property (@(posedge clock) disable iff (!rstSyncN_ff) // R7
      ce && byteStb_ff && state_ff == ST_REP_ARG && byte_ff != argHold_ff
      |=> !cmdValid_ff ##0 flags_ff.xferFault)
      else $error("mismatched repeat acted on");

   chk_fault_flag: assert property (@(posedge clock) disable iff (!rstSyncN_ff) // R9
      ce && xferSet |=> flags_ff.xferFault && errPin_ff)
      else $error("transfer fault not flagged");

   chk_stale_clear: assert property (@(posedge clock) disable iff (!rstSyncN_ff) // R10
      ce && errClr && !errCond.spkShort && !errCond.romFault
      |=> !flags_ff.spkShort && !flags_ff.romFault)
      else $error("ended fault not cleared");
endmodule // ecch_top

// *** ecch_host_model.sv ***
`timescale 1ns/1ns
module ecch_host_model
   import ecch_pkg::*;
(
   input  wire logic clock, // System clock
   output logic      csbN,  // Chip select, low within a byte
   output logic      sck,   // Serial clock, still between bytes
   output logic      si     // Serial data, MSB first
);
   // Clocks per sck phase; the device synchronises, so at least 3
   int halfClk = 4;

   initial begin
      csbN = 1'b1;
      sck  = 1'b1;
      si   = 1'b1;
   end

   task automatic sendByte(input logic [BYTE_W-1:0] b);
      csbN <= 1'b0;
      for (int i = BYTE_W - 1; i >= 0; i--) begin
         sck <= 1'b0;
         si  <= b[i];
         repeat (halfClk) @(posedge clock);
         sck <= 1'b1;
         repeat (halfClk) @(posedge clock);
      end
      // Released line flips so a stale bit cannot pass for data
      si   <= ~b[0];
      csbN <= 1'b1;
      repeat (halfClk) @(posedge clock);
   endtask

   // Bad flips bit 0 of the repeated argument, a broken two-time transfer
   task automatic sendCmd(input logic [BYTE_W-1:0] op, input logic [BYTE_W-1:0] arg,
                          input logic two, input logic twoTime, input logic bad = 1'b0);
      sendByte(op);
      if (two) begin
         sendByte(arg);
         if (twoTime) begin
            sendByte(op);
            sendByte(arg ^ {7'h00, bad});
         end
      end
   endtask
endmodule // ecch_host_model

// *** tb.sv ***
`timescale 1ns/1ns
module tb;
   import ecch_pkg::*;
   logic              clock = 1'b0;
   logic              rst_n = 1'b0;
   logic              ce = 1'b1;
   logic              csbN, sck, si, errPin, cmdValid, irq;
   ecch_cond_t        errCond = 4'h0;
   ecch_cmd_t         cmdOut;
   logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic              arvalid = 1'b0, rready = 1'b0;
   logic              awready, wready, bvalid, arready, rvalid;
   logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
   logic [DATA_W-1:0] wdata = 32'h0, rdata;
   logic [3:0]        wstrb = 4'h0;
   logic [1:0]        bresp, rresp;
   logic [7:0]        op;
   logic              two;
   logic [3:0]        condTab [3] = '{4'h1, 4'h2, 4'h8};
   logic [31:0]       statTab [3] = '{32'h1, 32'h2, 32'h10};
   int                n_errors = 0, compares = 0, nCmd = 0, n0;

   always #5 clock = ~clock;
   always @(posedge clock) if (cmdValid === 1'b1) nCmd++;

   ecch_top u_ecch_top (.clock(clock), .rst_n(rst_n), .ce(ce), .csbN(csbN), .sck(sck),
      .si(si), .errCond(errCond), .errPin(errPin), .cmdValid(cmdValid), .cmdOut(cmdOut),
      .irq(irq), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
   ecch_host_model u_ecch_host_model (.clock(clock), .csbN(csbN), .sck(sck), .si(si));

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] er = RESP_OKAY);
      bit         awDone, wDone, bDone;
      logic [1:0] r;
      awDone = 0;
      wDone = 0;
      bDone = 0;
      awvalid <= 1'b1;
      awaddr  <= a;
      wvalid  <= 1'b1;
      wdata   <= d;
      wstrb   <= 4'hF;
      bready  <= 1'b1;
      while (!bDone) begin
         @(posedge clock);
         if (!awDone && awready === 1'b1) begin
            awDone = 1;
            awvalid <= 1'b0;
         end
         if (!wDone && wready === 1'b1) begin
            wDone = 1;
            wvalid <= 1'b0;
         end
         if (bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            bDone = 1;
         end
      end
      @(posedge clock);
      chk("bresp", {30'h0, er}, {30'h0, r});
   endtask

   task automatic axiRead(input logic [7:0] a, input logic [31:0] exp,
                          input logic [1:0] er = RESP_OKAY);
      bit          arDone, rDone;
      logic [31:0] d;
      logic [1:0]  r;
      arDone = 0;
      rDone = 0;
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= 1'b1;
      while (!rDone) begin
         @(posedge clock);
         if (!arDone && arready === 1'b1) begin
            arDone = 1;
            arvalid <= 1'b0;
         end
         if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            rDone = 1;
         end
      end
      @(posedge clock);
      chk("rdata", exp, d);
      chk("rresp", {30'h0, er}, {30'h0, r});
   endtask

   task automatic pinIs(input logic e);
      repeat (4) @(posedge clock);
      chk("errPin", {31'h0, e}, {31'h0, errPin});
   endtask

   task automatic clearCmd();
      u_ecch_host_model.sendCmd(CMD_ERROR_CLEAR, 8'h00, 1'b0, 1'b0);
   endtask

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      repeat (50000) @(posedge clock);
      n_errors++;
      final_report();
   end

   initial begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      axiRead(ADDR_CTRL, 32'h0);
      axiRead(ADDR_ERR_STAT, 32'h0);
      axiRead(ADDR_IRQ_MASK, 32'h0);
      axiRead(8'h14, 32'h0, RESP_SLVERR);
      axiWrite(8'h14, 32'hFFFFFFFF, RESP_SLVERR);
      // Latched fault outlives its cause; clear only on the exact all-ones byte
      errCond <= 4'h4;
      @(posedge clock);
      errCond <= 4'h0;
      pinIs(1'b1);
      axiRead(ADDR_ERR_STAT, 32'h8);
      chk("irq", 0, {31'h0, irq});
      axiWrite(ADDR_IRQ_MASK, 32'h1);
      chk("irq", 1, {31'h0, irq});
      u_ecch_host_model.sendCmd(8'hFE, 8'h00, 1'b0, 1'b0);
      pinIs(1'b1);
      clearCmd();
      pinIs(1'b0);
      axiRead(ADDR_ERR_STAT, 32'h0);
      axiRead(ADDR_IRQ_STAT, 32'h5);
      axiWrite(ADDR_IRQ_STAT, 32'h5);
      axiRead(ADDR_IRQ_STAT, 32'h0);
      chk("irq", 0, {31'h0, irq});
      // Live fault survives the clear; recovery order status, amp off, clear
      for (int i = 0; i < 3; i++) begin
         errCond <= condTab[i];
         pinIs(1'b1);
         axiRead(ADDR_ERR_STAT, statTab[i]);
         u_ecch_host_model.sendCmd({HEAD_ANALOG_SETUP, 4'h0}, 8'h00, 1'b1, 1'b0);
         clearCmd();
         pinIs(1'b1);
         axiRead(ADDR_ERR_STAT, statTab[i]);
         errCond <= 4'h0;
         pinIs(1'b1);
         clearCmd();
         pinIs(1'b0);
         axiRead(ADDR_ERR_STAT, 32'h0);
      end
      // Every opcode head, alternating fast and slow host timing
      for (int i = 0; i < 16; i++) begin
         two = i inside {4, 7, 8, 9, 10, 11, 13, 14};
         op = {i[3:0], 4'h5};
         n0 = nCmd;
         u_ecch_host_model.halfClk = (i % 2) ? 3 : 6;
         u_ecch_host_model.sendCmd(op, 8'hA0 + i[7:0], two, 1'b0);
         repeat (4) @(posedge clock);
         chk("cmdOut", {15'h0, two, two ? 8'hA0 + i[7:0] : 8'h00, op},
             {15'h0, cmdOut.twoByte, cmdOut.arg, cmdOut.op});
         chk("cmdCount", n0 + 1, nCmd);
      end
      u_ecch_host_model.halfClk = 4;
      axiWrite(ADDR_CTRL, 32'h1);
      axiRead(ADDR_CTRL, 32'h1);
      axiWrite(ADDR_IRQ_MASK, 32'h2);
      n0 = nCmd;
      u_ecch_host_model.sendCmd(8'h8C, 8'h3C, 1'b1, 1'b1);
      pinIs(1'b0);
      chk("cmdCount", n0 + 1, nCmd);
      axiRead(ADDR_LAST_CMD, 32'h00013C8C);
      u_ecch_host_model.sendCmd(8'hE1, 8'h42, 1'b1, 1'b1, 1'b1);
      pinIs(1'b1);
      chk("cmdCount", n0 + 1, nCmd);
      axiRead(ADDR_ERR_STAT, 32'h4);
      chk("irq", 1, {31'h0, irq});
      axiRead(ADDR_LAST_CMD, 32'h00013C8C);
      clearCmd();
      pinIs(1'b0);
      axiRead(ADDR_ERR_STAT, 32'h0);
      axiWrite(ADDR_IRQ_STAT, 32'h7);
      chk("irq", 0, {31'h0, irq});
      // Frozen clock enable must ignore a fault pulse
      ce      <= 1'b0;
      errCond <= 4'h1;
      repeat (3) @(posedge clock);
      errCond <= 4'h0;
      ce      <= 1'b1;
      pinIs(1'b0);
      axiRead(ADDR_ERR_STAT, 32'h0);
      final_report();
   end
endmodule // tb
